/* File: shared/mcsc_pkg.sv */
// Purpose: Shared constants for the machine-check syndrome capture block
// Assumes: Register bits are numbered 32..63 from the most significant end
// Notes: Bit n of a 32-bit register sits at vector index 63-n

package mcsc_pkg;

  // Special register numbers
  localparam logic [9:0] SPR_ERROR_ADDRESS = 10'h23d;
  localparam logic [9:0] SPR_ERROR_ADDRESS_UPPER = 10'h239;
  localparam logic [9:0] SPR_ERROR_SYNDROME = 10'h2f0;
  localparam logic [9:0] SPR_EXT_PROXY_VECTOR = 10'h2f1;
  localparam logic [9:0] SPR_GUEST_EXT_PROXY_VECTOR = 10'h2f2;

  // Syndrome field positions as vector indices
  localparam int SYN_MC_INPUT_FLAG = 31;
  localparam int SYN_NMI_FLAG = 20;
  localparam int SYN_ADDRESS_VALID_FLAG = 19;
  localparam int SYN_EFFECTIVE_ADDRESS_FLAG = 18;

  // Reset values
  localparam logic [31:0] SYNDROME_RESET = 32'h0000_0000;
  localparam logic [63:0] ADDRESS_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] VECTOR_RESET = 32'h0000_0000;
  localparam logic [63:0] RDATA_RESET = 64'h0000_0000_0000_0000;

  // Access decode result
  typedef enum logic [2:0] {
    MCSC_SEL_NONE = 3'b000,
    MCSC_SEL_SYN = 3'b001,
    MCSC_SEL_ADDR = 3'b010,
    MCSC_SEL_ADDRU = 3'b011,
    MCSC_SEL_EPR = 3'b100,
    MCSC_SEL_GUEST_EXTERNAL_PROXY_VECTOR = 3'b101
  } mcsc_sel_t;

endpackage

/* File: src/mcsc_sync.sv */
// Purpose: Two-stage synchroniser for the machine check input pin
// Assumes: Pin is asynchronous to clk_sys
// Notes: First stage is read only by the second stage

`timescale 1ns/1ps

module mcsc_sync
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin_async,
  output logic pin_sync
);

  logic stage1;

  // Two flops to settle metastability before any logic looks
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      stage1 <= pin_async;
      pin_sync <= stage1;
    end
  end

endmodule

/* File: src/mcsc_capture.sv */
// Purpose: Machine-check syndrome, error address and external proxy vector capture
// Assumes: Special register moves arrive as one-cycle strobes on clk_sys
// Notes: Read data and privilege exception answer one cycle after the strobe

`timescale 1ns/1ps

module mcsc_capture
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic mc_pin,
  input wire logic nmi_deliver,
  input wire logic [31:0] err_report_set,
  input wire logic err_addr_valid,
  input wire logic [63:0] err_addr,
  input wire logic err_addr_is_ea,
  input wire logic machine_check_enable,
  input wire logic ext_int_taken,
  input wire logic ext_int_guest,
  input wire logic [31:0] ext_vector,
  input wire logic ext_int_reenabled,
  input wire logic hv_mode,
  input wire logic guest_super,
  input wire logic spr_rd,
  input wire logic spr_wr,
  input wire logic [9:0] spr_num,
  input wire logic [63:0] spr_wdata,
  output logic [63:0] spr_rdata,
  output logic spr_priv_exc,
  output logic mc_irq,
  output logic epr_valid,
  output logic guest_external_proxy_vector_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic mc_sync;
  logic [31:0] error_syndrome;
  logic [63:0] error_address;
  logic [31:0] external_proxy_vector;
  logic [31:0] guest_external_proxy_vector;

  mcsc_sync u_sync
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_async(mc_pin),
    .pin_sync(mc_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  // Guest supervisor reaches the guest vector through the proxy number
  function automatic mcsc_pkg::mcsc_sel_t decode_spr(input logic [9:0] num,
                                                     input logic guest);
    mcsc_pkg::mcsc_sel_t sel;
    sel = mcsc_pkg::MCSC_SEL_NONE;
    if (num == mcsc_pkg::SPR_ERROR_SYNDROME)
      sel = mcsc_pkg::MCSC_SEL_SYN;
    else if (num == mcsc_pkg::SPR_ERROR_ADDRESS)
      sel = mcsc_pkg::MCSC_SEL_ADDR;
    else if (num == mcsc_pkg::SPR_ERROR_ADDRESS_UPPER)
      sel = mcsc_pkg::MCSC_SEL_ADDRU;
    else if (num == mcsc_pkg::SPR_EXT_PROXY_VECTOR)
      sel = guest ? mcsc_pkg::MCSC_SEL_GUEST_EXTERNAL_PROXY_VECTOR : mcsc_pkg::MCSC_SEL_EPR;
    else if (num == mcsc_pkg::SPR_GUEST_EXT_PROXY_VECTOR)
      sel = mcsc_pkg::MCSC_SEL_GUEST_EXTERNAL_PROXY_VECTOR;
    return sel;
  endfunction

  wire mcsc_pkg::mcsc_sel_t rd_sel = decode_spr(spr_num, guest_super);
  wire mcsc_pkg::mcsc_sel_t wr_sel = decode_spr(spr_num, 1'b0);
  wire guest_epr_num = spr_num == mcsc_pkg::SPR_EXT_PROXY_VECTOR;

  // Reads: hypervisor sees all; guest supervisor only the redirected vector
  wire rd_allowed = hv_mode
    || (guest_super && guest_epr_num && rd_sel == mcsc_pkg::MCSC_SEL_GUEST_EXTERNAL_PROXY_VECTOR);
  wire rd_ok = spr_rd && rd_sel != mcsc_pkg::MCSC_SEL_NONE && rd_allowed;
  wire rd_bad = spr_rd && rd_sel != mcsc_pkg::MCSC_SEL_NONE && !rd_allowed;
  // Guest writes to the proxy number are never redirected
  wire wr_bad = spr_wr && wr_sel != mcsc_pkg::MCSC_SEL_NONE && !hv_mode;
  wire wr_syn = spr_wr && hv_mode && wr_sel == mcsc_pkg::MCSC_SEL_SYN;
  wire wr_guest_external_proxy_vector = spr_wr && hv_mode && wr_sel == mcsc_pkg::MCSC_SEL_GUEST_EXTERNAL_PROXY_VECTOR;

  ////////////////////////////////////////////////////////////////////////////
  // Syndrome set and clear
  // Capture only when no address is held yet
  wire addr_capture = err_addr_valid
    && !error_syndrome[mcsc_pkg::SYN_ADDRESS_VALID_FLAG];

  logic [31:0] hw_set;
  always_comb
  begin
    hw_set = err_report_set;
    hw_set[mcsc_pkg::SYN_MC_INPUT_FLAG] = mc_sync;
    hw_set[mcsc_pkg::SYN_NMI_FLAG] = nmi_deliver;
    hw_set[mcsc_pkg::SYN_ADDRESS_VALID_FLAG] = addr_capture;
    hw_set[mcsc_pkg::SYN_EFFECTIVE_ADDRESS_FLAG] = 1'b0;
  end

  // Clear mask uses the low word of the write data
  wire [31:0] sw_clear = wr_syn ? spr_wdata[31:0] : 32'h0000_0000;

  logic [31:0] next_syndrome;
  always_comb
  begin
    next_syndrome = (error_syndrome & ~sw_clear) | hw_set;
    if (addr_capture)
      next_syndrome[mcsc_pkg::SYN_EFFECTIVE_ADDRESS_FLAG] = err_addr_is_ea;
  end

  // Flags and address share one edge so no stale pairing is visible
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      error_syndrome <= mcsc_pkg::SYNDROME_RESET;
      error_address <= mcsc_pkg::ADDRESS_RESET;
    end
    else
    begin
      error_syndrome <= next_syndrome;
      if (addr_capture)
        error_address <= err_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request
  // Level sensitive: held while any bit stays set, so enabling with
  // leftovers fires at once; the pin bit keeps firing until cleared
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      mc_irq <= 1'b0;
    else
      mc_irq <= machine_check_enable && (|error_syndrome);
  end

  ////////////////////////////////////////////////////////////////////////////
  // External proxy vectors
  // Valid until the controller reports re-enable; a new take wins
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      external_proxy_vector <= mcsc_pkg::VECTOR_RESET;
      guest_external_proxy_vector <= mcsc_pkg::VECTOR_RESET;
      epr_valid <= 1'b0;
      guest_external_proxy_vector_valid <= 1'b0;
    end
    else
    begin
      if (ext_int_taken && !ext_int_guest)
        external_proxy_vector <= ext_vector;
      if (ext_int_taken && ext_int_guest)
        guest_external_proxy_vector <= ext_vector;
      else if (wr_guest_external_proxy_vector)
        guest_external_proxy_vector <= spr_wdata[31:0];
      epr_valid <= (ext_int_taken && !ext_int_guest)
        || (epr_valid && !ext_int_reenabled);
      guest_external_proxy_vector_valid <= (ext_int_taken && ext_int_guest)
        || (guest_external_proxy_vector_valid && !ext_int_reenabled);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and exception
  // Narrow registers sit in the low bits, the rest read zero
  logic [63:0] rd_mux;
  always_comb
  begin
    case (rd_sel)
      mcsc_pkg::MCSC_SEL_SYN: rd_mux = {32'h0000_0000, error_syndrome};
      mcsc_pkg::MCSC_SEL_ADDR: rd_mux = error_address;
      mcsc_pkg::MCSC_SEL_ADDRU: rd_mux = {32'h0000_0000, error_address[63:32]};
      mcsc_pkg::MCSC_SEL_EPR: rd_mux = {32'h0000_0000, external_proxy_vector};
      mcsc_pkg::MCSC_SEL_GUEST_EXTERNAL_PROXY_VECTOR: rd_mux = {32'h0000_0000, guest_external_proxy_vector};
      default: rd_mux = 64'h0000_0000_0000_0000;
    endcase
  end

  // Read data holds until the next read so slow consumers can sample late
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      spr_rdata <= mcsc_pkg::RDATA_RESET;
      spr_priv_exc <= 1'b0;
    end
    else
    begin
      if (spr_rd)
        spr_rdata <= rd_ok ? rd_mux : 64'h0000_0000_0000_0000;
      spr_priv_exc <= rd_bad || wr_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_capture;
    err_addr_valid && !error_syndrome[mcsc_pkg::SYN_ADDRESS_VALID_FLAG];
  endsequence

  sequence s_locked;
    err_addr_valid && error_syndrome[mcsc_pkg::SYN_ADDRESS_VALID_FLAG];
  endsequence

  chk_addr_capture_load: assert property (
    s_capture |=> error_address == $past(err_addr)
      && error_syndrome[mcsc_pkg::SYN_ADDRESS_VALID_FLAG]
      && error_syndrome[mcsc_pkg::SYN_EFFECTIVE_ADDRESS_FLAG] == $past(err_addr_is_ea))
    else $error("address capture not loaded together with flags");

  chk_addr_locked_hold: assert property (
    s_locked |=> $stable(error_address))
    else $error("captured address overwritten while valid");

  chk_syndrome_w1c: assert property (
    wr_syn && hw_set == 32'h0000_0000 && !addr_capture
      |=> error_syndrome == ($past(error_syndrome) & ~$past(spr_wdata[31:0])))
    else $error("syndrome write did not clear as mask");

  chk_set_beats_clear: assert property (
    nmi_deliver && wr_syn |=> error_syndrome[mcsc_pkg::SYN_NMI_FLAG])
    else $error("clear won over same-cycle set");

  chk_pin_sets_flag: assert property (
    $rose(mc_pin) ##1 mc_pin |=> ##1 error_syndrome[mcsc_pkg::SYN_MC_INPUT_FLAG])
    else $error("machine check pin did not set input flag");

  chk_irq_level: assert property (
    machine_check_enable && (|error_syndrome) |=> mc_irq)
    else $error("interrupt missing with syndrome set and enabled");

  chk_irq_quiet: assert property (
    !machine_check_enable |=> !mc_irq)
    else $error("interrupt raised while checks disabled");

  chk_epr_load: assert property (
    ext_int_taken && !ext_int_guest
      |=> external_proxy_vector == $past(ext_vector) && epr_valid)
    else $error("proxy vector not loaded on take");

  chk_guest_external_proxy_vector_load: assert property (
    ext_int_taken && ext_int_guest |=> guest_external_proxy_vector == $past(ext_vector)
      && $stable(external_proxy_vector))
    else $error("guest vector not loaded on guest take");

  chk_guest_read_map: assert property (
    spr_rd && guest_super && !hv_mode && guest_epr_num
      |=> spr_rdata == {32'h0000_0000, $past(guest_external_proxy_vector)} && !spr_priv_exc)
    else $error("guest read of proxy vector not redirected");

  chk_guest_write_exc: assert property (
    spr_wr && !hv_mode && guest_epr_num
      |=> spr_priv_exc && $stable(guest_external_proxy_vector))
    else $error("guest write to proxy vector not refused");

  chk_upper_alias: assert property (
    spr_rd && hv_mode && spr_num == mcsc_pkg::SPR_ERROR_ADDRESS_UPPER && !addr_capture
      |=> spr_rdata[31:0] == error_address[63:32])
    else $error("upper address does not alias high half");

  ////////////////////////////////////////////////////////////////////////////
  // Flag, interrupt and access checks that random traffic rarely trips alone
  sequence s_refused_read;
    spr_rd && !hv_mode && !guest_super && spr_num == mcsc_pkg::SPR_ERROR_ADDRESS;
  endsequence

  chk_report_recorded: assert property (
    err_report_set[0] |=> error_syndrome[0])
    else $error("error report bit not recorded");

  chk_valid_flag_clear: assert property (
    wr_syn && spr_wdata[mcsc_pkg::SYN_ADDRESS_VALID_FLAG] && !addr_capture
      |=> !error_syndrome[mcsc_pkg::SYN_ADDRESS_VALID_FLAG])
    else $error("address valid flag survived its clear");

  chk_ea_flag_held: assert property (
    err_addr_valid && error_syndrome[mcsc_pkg::SYN_ADDRESS_VALID_FLAG] && !wr_syn
      |=> $stable(error_syndrome[mcsc_pkg::SYN_EFFECTIVE_ADDRESS_FLAG]))
    else $error("address type changed while address locked");

  chk_nmi_sets: assert property (
    nmi_deliver |=> error_syndrome[mcsc_pkg::SYN_NMI_FLAG])
    else $error("delivered NMI not recorded");

  chk_irq_clear_quiet: assert property (
    error_syndrome == 32'h0000_0000 |=> !mc_irq)
    else $error("interrupt raised with empty syndrome");

  chk_irq_on_enable: assert property (
    $rose(machine_check_enable) && (|error_syndrome) |=> mc_irq)
    else $error("leftover syndrome bits did not interrupt on enable");

  chk_addr_read_refused: assert property (
    s_refused_read |=> spr_priv_exc && spr_rdata == 64'h0000_0000_0000_0000)
    else $error("address read without hypervisor privilege not refused");

  chk_exc_quiet: assert property (
    !spr_rd && !spr_wr |=> !spr_priv_exc)
    else $error("privilege exception without an access");

  chk_guest_write_epr: assert property (
    spr_wr && !hv_mode && guest_epr_num && !ext_int_taken
      |=> $stable(external_proxy_vector))
    else $error("guest write reached the proxy vector");

  chk_epr_valid_hold: assert property (
    epr_valid && !ext_int_reenabled |=> epr_valid)
    else $error("proxy vector validity dropped early");

  chk_guest_external_proxy_vector_valid_hold: assert property (
    guest_external_proxy_vector_valid && !ext_int_reenabled |=> guest_external_proxy_vector_valid)
    else $error("guest vector validity dropped early");

  chk_valid_end: assert property (
    ext_int_reenabled && !ext_int_taken |=> !epr_valid && !guest_external_proxy_vector_valid)
    else $error("proxy vector still valid after re-enable");

endmodule

/* File: bench/mcsc_pic_model.sv */
// Purpose: Interrupt controller stand-in that takes an external interrupt
// Assumes: fire is a one-cycle request sampled on the rising edge
// Notes: Vector bus shows 0f0f_0f0f until the first take, then the inverse of the last vector outside a take
`timescale 1ns/1ps
module mcsc_pic_model
(
  input wire logic clk_sys,
  input wire logic fire,
  input wire logic [3:0] delay,
  input wire logic [31:0] vec,
  output logic ext_int_taken,
  output logic [31:0] ext_vector
);
  // Idle bus pattern, so a late sample never sees a held vector;
  // one process owns both outputs
  initial
  begin
    ext_int_taken = 1'b0;
    ext_vector = 32'h0f0f_0f0f;
    forever
    begin
      @(posedge clk_sys);
      // Wait the chosen latency, then present the vector for one cycle
      if (fire)
      begin
        repeat (delay) @(posedge clk_sys);
        @(negedge clk_sys);
        ext_int_taken = 1'b1;
        ext_vector = vec;
        @(negedge clk_sys);
        ext_int_taken = 1'b0;
        ext_vector = ~vec; // Released
      end
    end
  end
endmodule

/* File: bench/machine_check_syndrome_capture_tb.sv */
// Purpose: Self-checking bench for the syndrome capture block
// Assumes: Inputs change at the falling edge; tasks start there
// Notes: Random values come from an LFSR seeded with 12
`timescale 1ns/1ps
module machine_check_syndrome_capture_tb;
  localparam logic [9:0] SYN = mcsc_pkg::SPR_ERROR_SYNDROME;
  localparam logic [9:0] ADR = mcsc_pkg::SPR_ERROR_ADDRESS;
  localparam logic [9:0] ADU = mcsc_pkg::SPR_ERROR_ADDRESS_UPPER;
  localparam logic [9:0] EPV = mcsc_pkg::SPR_EXT_PROXY_VECTOR;
  localparam logic [9:0] GPV = mcsc_pkg::SPR_GUEST_EXT_PROXY_VECTOR;
  logic clk_sys, reset, mc_pin, nmi_deliver, err_addr_valid, err_addr_is_ea;
  logic machine_check_enable, ext_int_taken, ext_int_guest, ext_int_reenabled;
  logic hv_mode, guest_super, spr_rd, spr_wr, spr_priv_exc, mc_irq;
  logic epr_valid, guest_external_proxy_vector_valid, fire, exc;
  logic [3:0] delay;
  logic [9:0] spr_num;
  logic [31:0] err_report_set, ext_vector, vec, seed, r;
  logic [63:0] err_addr, spr_wdata, spr_rdata, a;
  int fail_count = 0;
  int n_tests = 0;

  mcsc_capture uut
  (
    .clk_sys(clk_sys), .reset(reset), .mc_pin(mc_pin), .nmi_deliver(nmi_deliver),
    .err_report_set(err_report_set), .err_addr_valid(err_addr_valid),
    .err_addr(err_addr), .err_addr_is_ea(err_addr_is_ea),
    .machine_check_enable(machine_check_enable), .ext_int_taken(ext_int_taken),
    .ext_int_guest(ext_int_guest), .ext_vector(ext_vector),
    .ext_int_reenabled(ext_int_reenabled), .hv_mode(hv_mode),
    .guest_super(guest_super), .spr_rd(spr_rd), .spr_wr(spr_wr), .spr_num(spr_num),
    .spr_wdata(spr_wdata), .spr_rdata(spr_rdata), .spr_priv_exc(spr_priv_exc),
    .mc_irq(mc_irq), .epr_valid(epr_valid), .guest_external_proxy_vector_valid(guest_external_proxy_vector_valid)
  );

  mcsc_pic_model pic
  (
    .clk_sys(clk_sys), .fire(fire), .delay(delay), .vec(vec),
    .ext_int_taken(ext_int_taken), .ext_vector(ext_vector)
  );

  // 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Syndrome bit n sits at index 63-n
  function automatic logic [63:0] sbit(input int n);
    return 64'h1 << (63 - n);
  endfunction

  task automatic tick();
    @(negedge clk_sys);
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One special register move; the one-cycle exception is caught while it
  // stands, and a quiet cycle keeps back-to-back strobes apart
  task automatic spr(input logic rd, input logic wr, input logic [9:0] n,
    input logic [63:0] wd);
    spr_rd = rd;
    spr_wr = wr;
    spr_num = n;
    spr_wdata = wd;
    tick();
    exc = spr_priv_exc;
    spr_rd = 1'b0;
    spr_wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [9:0] n);
    spr(1'b1, 1'b0, n, 64'h0);
  endtask

  task automatic take(input logic [3:0] d);
    seed = lfsr(seed);
    vec = seed;
    delay = d;
    fire = 1'b1;
    tick();
    fire = 1'b0;
  endtask

  // Bounded wait on a proxy valid flag
  task automatic wait_hi(input logic guest);
    int i;
    for (i = 0; i < 20 && (guest ? guest_external_proxy_vector_valid : epr_valid) !== 1'b1; i++) tick();
    if (i == 20)
    begin
      fail_count++;
      $display("Error at %0t: valid never rose", $time);
      report_and_stop();
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {mc_pin, nmi_deliver, err_addr_valid, err_addr_is_ea, machine_check_enable} = '0;
    {ext_int_guest, ext_int_reenabled, guest_super, spr_rd, spr_wr, fire} = '0;
    {err_report_set, err_addr, spr_wdata, vec, delay, spr_num} = '0;
    hv_mode = 1'b1;
    seed = 32'h0000_000c;
    reset = 1'b1;
    repeat (4) @(posedge clk_sys);
    tick();
    reset = 1'b0;
    tick();
    rd(SYN);
    check(spr_rdata, 64'h0);
    rd(10'h3ff);
    check({spr_rdata[62:0], exc}, 64'h0); // Unmapped: quiet zero
    // Random report bits; flag positions are not report sources
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      r = seed & ~32'h801c_0000;
      err_report_set = seed;
      tick();
      err_report_set = '0;
      rd(SYN);
      check(spr_rdata, {32'h0, r});
      seed = lfsr(seed);
      spr(1'b0, 1'b1, SYN, {32'h0, seed});
      rd(SYN);
      check(spr_rdata, {32'h0, r & ~seed});
      check({63'h0, mc_irq}, 64'h0);
      machine_check_enable = 1'b1;
      repeat (2) tick();
      check({63'h0, mc_irq}, {63'h0, |(r & ~seed)});
      rd(SYN);
      spr(1'b0, 1'b1, SYN, spr_rdata);
      repeat (2) tick();
      check({63'h0, mc_irq}, 64'h0);
      machine_check_enable = 1'b0;
    end
    mc_pin = 1'b1;
    repeat (4) tick();
    mc_pin = 1'b0;
    repeat (3) tick();
    rd(SYN);
    check(spr_rdata, sbit(32));
    // NMI set lands in the same cycle as its clear
    nmi_deliver = 1'b1;
    {spr_wr, spr_num, spr_wdata} = {1'b1, SYN, sbit(32) | sbit(43)};
    tick();
    {nmi_deliver, spr_wr} = 2'b00;
    tick();
    rd(SYN);
    check(spr_rdata, sbit(43));
    spr(1'b0, 1'b1, SYN, spr_rdata);
    // Two addressed errors back to back; only the first is kept
    seed = lfsr(seed);
    a[31:0] = seed;
    seed = lfsr(seed);
    a[63:32] = seed;
    {err_addr_valid, err_addr_is_ea, err_addr} = {2'b11, a};
    tick();
    {err_addr_is_ea, err_addr} = {1'b0, ~a};
    tick();
    err_addr_valid = 1'b0;
    rd(SYN);
    check(spr_rdata, sbit(44) | sbit(45));
    rd(ADR);
    check(spr_rdata, a);
    rd(ADU);
    check(spr_rdata, {32'h0, a[63:32]});
    spr(1'b0, 1'b1, SYN, sbit(44) | sbit(45));
    rd(SYN);
    check(spr_rdata, 64'h0);
    {err_addr_valid, err_addr} = {1'b1, ~a};
    tick();
    {err_addr_valid, err_addr} = {1'b0, a};
    rd(SYN);
    check(spr_rdata, sbit(44));
    rd(ADR);
    check(spr_rdata, ~a);
    hv_mode = 1'b0;
    rd(ADR);
    check({spr_rdata[62:0], exc}, 64'h1);
    // Proxy vector, hypervisor then guest
    hv_mode = 1'b1;
    take(4'h0);
    wait_hi(1'b0);
    rd(EPV);
    check(spr_rdata, {32'h0, vec});
    ext_int_reenabled = 1'b1;
    tick();
    ext_int_reenabled = 1'b0;
    tick();
    check({63'h0, epr_valid}, 64'h0);
    ext_int_guest = 1'b1;
    take(4'h3);
    wait_hi(1'b1);
    ext_int_guest = 1'b0;
    check({63'h0, epr_valid}, 64'h0);
    ext_int_reenabled = 1'b1;
    tick();
    ext_int_reenabled = 1'b0;
    tick();
    check({63'h0, guest_external_proxy_vector_valid}, 64'h0);
    {hv_mode, guest_super} = 2'b01;
    rd(EPV);
    check({spr_rdata[62:0], exc}, {31'h0, vec, 1'b0});
    spr(1'b0, 1'b1, EPV, 64'h0);
    check({63'h0, exc}, 64'h1);
    rd(EPV);
    check(spr_rdata, {32'h0, vec});
    // Direct guest reach of the guest vector number is refused
    rd(GPV);
    check({63'h0, exc}, 64'h1);
    {hv_mode, guest_super} = 2'b10;
    spr(1'b0, 1'b1, GPV, {32'h0, ~vec});
    {hv_mode, guest_super} = 2'b01;
    rd(EPV);
    check(spr_rdata, {32'h0, ~vec});
    report_and_stop();
  end
endmodule
